// file: mrs_pkg.sv
// Constants, enumerations and carrier types of the RTU serial slave.
// Assumes a 10 MHz system clock and one Avalon-MM master for settings.
//
// Functional notes
// - Transmit only as the answer to a fully received request.
// - Act only on requests whose first byte equals the station address 1..255.
// - Address 0 is broadcast: writes execute, nothing is ever sent back.
// - Code 03 reads holding registers, at most 11 per request.
// - Code 04 reads input registers, at most 11 per request.
// - Code 10 hex writes up to 11 registers, executes on broadcast.
// - Each frame ends in a 16 bit CRC, checked beside character parity.
// - CRC runs per received byte and is compared at frame end.
// - Answer starts no earlier than 3.5 characters after request end; timed here from the stop bit sample, up to 1.5 bits earlier.
// - Successful 06 or 16 write echoes the request unchanged.
// - Successful read returns address, function code and register data.
// - Valid frame with a bad request executes nothing and gets an exception.
// - Exception codes 01, 02, 03, 04 and 06.
// - Silence on transmission, CRC or parity error or foreign address.
// - Bad data length gets no answer and raises the invalid-length fault.
// - Each CRC-rejected frame adds one to the faulty-message count.
// - A request closer than 3.5 characters to the previous message is ignored.
// - Counters: faulty messages 0..64, correct messages 0..999.
// - No parity uses two stop bits, even or odd parity one.
// - Baud code 0..8 selects 300 to 57600 baud.
// - Timeout 1..255 s without messages raises bus error 53; 0 disables.
package mrs_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int BITS_PER_CHAR = 11;
   localparam int REST_HALF_CHARS = 7;
   localparam int BAUD_TAB [0:8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600};

   // ****************************************
   // Protocol
   // ****************************************
   localparam int MAX_REGS = 11;
   localparam int BUF_BYTES = 32;
   localparam int FAULTY_MAX = 64;
   localparam int CORRECT_MAX = 999;
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INPUT = 8'h04;
   localparam logic [7:0] FC_WR_ONE = 8'h06;
   localparam logic [7:0] FC_WR_MULTI = 8'h10;
   localparam logic [7:0] FC_EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [7:0] EXC_DEVICE = 8'h04;
   localparam logic [7:0] EXC_BUSY = 8'h06;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [7:0] BUS_ERR_CODE = 8'h35;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;

   // ****************************************
   // Register map (byte offsets) and reset values
   // ****************************************
   localparam logic [7:0] OFS_STATION = 8'h00;
   localparam logic [7:0] OFS_BAUD = 8'h04;
   localparam logic [7:0] OFS_PARITY = 8'h08;
   localparam logic [7:0] OFS_TIMEOUT = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_HOLD = 8'h40;
   localparam logic [7:0] RST_STATION = 8'h01;
   localparam logic [3:0] RST_BAUD = 4'h5;
   localparam logic [1:0] RST_PARITY = 2'h0;
   localparam logic [7:0] RST_TIMEOUT = 8'h00;
   localparam int CTRL_CLR_CNT = 0;
   localparam int CTRL_BUSY = 1;
   localparam int CTRL_CLR_LEN = 2;
   localparam int CTRL_CLR_TMO = 3;

   typedef enum logic [5:0] {
      ST_RX = 6'h01,
      ST_EXEC = 6'h02,
      ST_READ = 6'h04,
      ST_WRITE = 6'h08,
      ST_CHECK = 6'h10,
      ST_TX = 6'h20
   } mrs_state_t;

   typedef struct packed {
      logic [7:0] station;
      logic [3:0] baud;
      logic [1:0] parity;
      logic [7:0] timeout;
      logic busy;
   } mrs_cfg_t;

endpackage

// file: mrs_slave.sv
// RTU serial slave: receiver, frame interpreter, responder and settings.
// Assumes an RS-485 transceiver outside: rx pin async, de drives the line.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
module mrs_slave #(
   parameter int CLK_HZ = mrs_pkg::CLK_HZ,
   parameter int NREG = 16
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic rs485_rx_i,
   output logic rs485_tx_o,
   output logic rs485_de_o,
   output logic invalid_length_fault_o,
   output logic bus_timeout_fault_o
);

   localparam int RW = $clog2(NREG);

   typedef struct packed {
      logic rx_s1;
      logic rx_s2;
      logic rx_on;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [8:0] rx_sh;
      logic [23:0] idle;
      logic [5:0] n;
      logic bad;
      logic [15:0] crc;
      logic [mrs_pkg::BUF_BYTES-1:0][7:0] fb;
      logic [NREG-1:0][15:0] regs;
      mrs_pkg::mrs_state_t st;
      logic [3:0] idx;
      logic [3:0] qty;
      logic [15:0] ra;
      logic [5:0] len;
      logic [5:0] pos;
      logic [15:0] tcnt;
      logic [3:0] tbit;
      logic [10:0] tsh;
      logic [15:0] tcrc;
      logic txd;
      logic de;
      logic [6:0] faulty;
      logic [9:0] good;
      logic len_flt;
      logic tmo_flt;
      logic [31:0] sec;
      logic [7:0] secs;
      mrs_pkg::mrs_cfg_t cfg;
      logic ack;
      logic [31:0] rdata;
   } mrs_st_t;

   mrs_st_t s_q;
   mrs_st_t s_d;
   logic [15:0] div_tab [0:8];

   // ****************************************
   // Bit period per baud code
   // ****************************************
   for (genvar g = 0; g < 9; g++)
   begin : g_div
      assign div_tab[g] = 16'(CLK_HZ / mrs_pkg::BAUD_TAB[g]);
   end

   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++)
      begin
         r = r[0] ? ((r >> 1) ^ mrs_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   assign avs_readdata_o = s_q.rdata;
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_q.ack;
   assign rs485_tx_o = s_q.txd;
   assign rs485_de_o = s_q.de;
   assign invalid_length_fault_o = s_q.len_flt;
   assign bus_timeout_fault_o = s_q.tmo_flt;

   logic [15:0] bitdiv;
   logic [23:0] t35;
   logic par_en;
   logic [3:0] stop_idx;
   logic [7:0] rbyte;
   logic perr;
   logic [31:0] rmux;
   logic [31:0] wmerged;
   logic [7:0] fc;
   logic [15:0] qword;
   logic bcast;
   logic [7:0] exc;
   logic lenbad;
   logic [16:0] rend;
   logic [RW-1:0] widx;
   logic [15:0] wval;
   logic [7:0] tbyte;

   always_comb
   begin
      s_d = s_q;
      bitdiv = (s_q.cfg.baud <= 4'h8) ? div_tab[s_q.cfg.baud] : div_tab[0];
      // Rest time = 3.5 characters of eleven bits each
      t35 = 24'((32'(bitdiv) * mrs_pkg::BITS_PER_CHAR * mrs_pkg::REST_HALF_CHARS) / 2);
      par_en = s_q.cfg.parity != mrs_pkg::PAR_NONE;
      stop_idx = par_en ? 4'hA : 4'h9;
      rbyte = par_en ? s_q.rx_sh[7:0] : s_q.rx_sh[8:1];
      perr = par_en && ((^s_q.rx_sh) != (s_q.cfg.parity == mrs_pkg::PAR_ODD));
      fc = s_q.fb[1];
      qword = {s_q.fb[4], s_q.fb[5]};
      bcast = s_q.fb[0] == mrs_pkg::BCAST_ADDR;
      exc = 8'h00;
      lenbad = 1'b0;
      rend = {1'b0, s_q.fb[2], s_q.fb[3]} + {1'b0, qword};
      widx = RW'(s_q.ra + 16'(s_q.idx));
      wval = (fc == mrs_pkg::FC_WR_ONE) ? qword :
             {s_q.fb[5'(7 + 2 * s_q.idx)], s_q.fb[5'(8 + 2 * s_q.idx)]};
      tbyte = (s_q.pos < s_q.len) ? s_q.fb[5'(s_q.pos)] :
              (s_q.pos == s_q.len) ? s_q.tcrc[7:0] : s_q.tcrc[15:8];

      // ****************************************
      // Settings bus: one wait cycle, then the answer
      // ****************************************
      case (avs_address_i)
         mrs_pkg::OFS_STATION: rmux = {24'h000000, s_q.cfg.station};
         mrs_pkg::OFS_BAUD: rmux = {28'h0000000, s_q.cfg.baud};
         mrs_pkg::OFS_PARITY: rmux = {30'h00000000, s_q.cfg.parity};
         mrs_pkg::OFS_TIMEOUT: rmux = {24'h000000, s_q.cfg.timeout};
         mrs_pkg::OFS_CTRL: rmux = {30'h00000000, s_q.cfg.busy, 1'b0};
         mrs_pkg::OFS_STATUS: rmux = {(s_q.tmo_flt ? mrs_pkg::BUS_ERR_CODE : 8'h00),
                                      s_q.len_flt, s_q.faulty, 6'h00, s_q.good};
         default: rmux = 32'h00000000;
      endcase
      if (avs_address_i >= mrs_pkg::OFS_HOLD && avs_address_i[1:0] == 2'h0 &&
          32'(avs_address_i[7:2] - mrs_pkg::OFS_HOLD[7:2]) < NREG)
         rmux = {16'h0000, s_q.regs[RW'(avs_address_i[7:2] - mrs_pkg::OFS_HOLD[7:2])]};
      for (int b = 0; b < 4; b++)
      begin
         wmerged[8*b +: 8] = avs_byteenable_i[b] ? avs_writedata_i[8*b +: 8] : rmux[8*b +: 8];
      end
      s_d.ack = 1'b0;
      if ((avs_read_i || avs_write_i) && !s_q.ack)
      begin
         s_d.ack = 1'b1;
         s_d.rdata = avs_read_i ? rmux : s_q.rdata;
      end
      if (avs_write_i && s_q.ack)
      begin
         case (avs_address_i)
            mrs_pkg::OFS_STATION: if (wmerged[7:0] != 8'h00) s_d.cfg.station = wmerged[7:0];
            mrs_pkg::OFS_BAUD: if (wmerged[3:0] <= 4'h8 && wmerged[31:4] == '0)
               s_d.cfg.baud = wmerged[3:0];
            mrs_pkg::OFS_PARITY: if (wmerged[1:0] != 2'h3) s_d.cfg.parity = wmerged[1:0];
            mrs_pkg::OFS_TIMEOUT: s_d.cfg.timeout = wmerged[7:0];
            mrs_pkg::OFS_CTRL:
            begin
               s_d.cfg.busy = wmerged[mrs_pkg::CTRL_BUSY];
               if (wmerged[mrs_pkg::CTRL_CLR_CNT])
               begin
                  s_d.faulty = '0;
                  s_d.good = '0;
               end
               if (wmerged[mrs_pkg::CTRL_CLR_LEN]) s_d.len_flt = 1'b0;
               if (wmerged[mrs_pkg::CTRL_CLR_TMO]) s_d.tmo_flt = 1'b0;
            end
            default: if (avs_address_i >= mrs_pkg::OFS_HOLD && rmux == wmerged) s_d.rdata = s_q.rdata;
         endcase
         if (avs_address_i >= mrs_pkg::OFS_HOLD && avs_address_i[1:0] == 2'h0 &&
             32'(avs_address_i[7:2] - mrs_pkg::OFS_HOLD[7:2]) < NREG)
            s_d.regs[RW'(avs_address_i[7:2] - mrs_pkg::OFS_HOLD[7:2])] = wmerged[15:0];
      end

      // ****************************************
      // Character receiver
      // ****************************************
      s_d.rx_s1 = rs485_rx_i;
      s_d.rx_s2 = s_q.rx_s1;
      if (!s_q.rx_on)
      begin
         if (s_q.idle != '1) s_d.idle = s_q.idle + 24'h000001;
         if (s_q.st == mrs_pkg::ST_RX && !s_q.rx_s2)
         begin
            s_d.rx_on = 1'b1;
            s_d.rx_cnt = bitdiv >> 1;
            s_d.rx_bit = 4'h0;
            if (s_q.n == 6'h00 && s_q.idle < t35) s_d.bad = 1'b1;
         end
      end
      else
      begin
         s_d.idle = '0;
         if (s_q.rx_cnt != 16'h0000) s_d.rx_cnt = s_q.rx_cnt - 16'h0001;
         else
         begin
            s_d.rx_cnt = bitdiv - 16'h0001;
            s_d.rx_bit = s_q.rx_bit + 4'h1;
            if (s_q.rx_bit == 4'h0)
            begin
               if (s_q.rx_s2) s_d.rx_on = 1'b0;
            end
            else if (s_q.rx_bit < stop_idx) s_d.rx_sh = {s_q.rx_s2, s_q.rx_sh[8:1]};
            else
            begin
               s_d.rx_on = 1'b0;
               if (!s_q.rx_s2 || perr) s_d.bad = 1'b1;
               if (s_q.n < 6'(mrs_pkg::BUF_BYTES))
               begin
                  s_d.fb[5'(s_q.n)] = rbyte;
                  s_d.n = s_q.n + 6'h01;
                  s_d.crc = crc_upd(s_q.crc, rbyte);
               end
               else s_d.bad = 1'b1;
            end
         end
      end

      // ****************************************
      // Bus silence supervision
      // ****************************************
      if (s_q.cfg.timeout == 8'h00)
      begin
         s_d.sec = '0;
         s_d.secs = '0;
      end
      else if (s_q.sec == 32'(CLK_HZ - 1))
      begin
         s_d.sec = '0;
         if (s_q.secs != 8'hFF) s_d.secs = s_q.secs + 8'h01;
      end
      else s_d.sec = s_q.sec + 32'h00000001;
      if (s_q.cfg.timeout != 8'h00 && s_q.secs >= s_q.cfg.timeout) s_d.tmo_flt = 1'b1;

      // ****************************************
      // Frame interpreter and responder
      // ****************************************
      case (s_q.st)
         mrs_pkg::ST_RX:
            // Silence of 3.5 characters, counted from the stop bit sample, closes the frame, so the answer
            // can start up to 1.5 bit times inside the rest time after the request end
            if (!s_q.rx_on && s_q.n != 6'h00 && s_q.idle >= t35) s_d.st = mrs_pkg::ST_EXEC;
         mrs_pkg::ST_EXEC:
         begin
            s_d.st = mrs_pkg::ST_RX;
            s_d.n = '0;
            s_d.bad = 1'b0;
            s_d.crc = mrs_pkg::CRC_INIT;
            s_d.idx = '0;
            s_d.ra = {s_q.fb[2], s_q.fb[3]};
            s_d.len = s_q.n - 6'h02;
            if (s_q.bad || s_q.n < 6'h04) s_d.st = mrs_pkg::ST_RX;
            else if (s_q.crc != 16'h0000)
            begin
               if (s_q.faulty < 7'(mrs_pkg::FAULTY_MAX)) s_d.faulty = s_q.faulty + 7'h01;
            end
            else if (bcast || s_q.fb[0] == s_q.cfg.station)
            begin
               if (s_q.good < 10'(mrs_pkg::CORRECT_MAX)) s_d.good = s_q.good + 10'h001;
               s_d.sec = '0;
               s_d.secs = '0;
               case (fc)
                  mrs_pkg::FC_RD_HOLD, mrs_pkg::FC_RD_INPUT:
                     if (s_q.n != 6'h08 || qword > 16'(mrs_pkg::MAX_REGS)) lenbad = 1'b1;
                     else if (qword == 16'h0000) exc = mrs_pkg::EXC_VALUE;
                     else if (rend > 17'(NREG)) exc = mrs_pkg::EXC_ADDR;
                     else if (s_q.cfg.busy) exc = mrs_pkg::EXC_BUSY;
                     else if (!bcast) s_d.st = mrs_pkg::ST_READ;
                  mrs_pkg::FC_WR_ONE:
                     if (s_q.n != 6'h08) lenbad = 1'b1;
                     else if ({s_q.fb[2], s_q.fb[3]} >= 16'(NREG)) exc = mrs_pkg::EXC_ADDR;
                     else if (s_q.cfg.busy) exc = mrs_pkg::EXC_BUSY;
                     else s_d.st = mrs_pkg::ST_WRITE;
                  mrs_pkg::FC_WR_MULTI:
                     if (s_q.n < 6'h09 || qword > 16'(mrs_pkg::MAX_REGS)) lenbad = 1'b1;
                     else if (qword == 16'h0000 || s_q.fb[6] != 8'(2 * qword) ||
                              s_q.n != 6'(9 + 2 * qword)) exc = mrs_pkg::EXC_VALUE;
                     else if (rend > 17'(NREG)) exc = mrs_pkg::EXC_ADDR;
                     else if (s_q.cfg.busy) exc = mrs_pkg::EXC_BUSY;
                     else s_d.st = mrs_pkg::ST_WRITE;
                  default: exc = mrs_pkg::EXC_FUNC;
               endcase
               s_d.qty = (fc == mrs_pkg::FC_WR_ONE) ? 4'h1 : qword[3:0];
               if (lenbad) s_d.len_flt = 1'b1;
               if (exc != 8'h00 && !bcast)
               begin
                  s_d.fb[1] = fc | mrs_pkg::FC_EXC_FLAG;
                  s_d.fb[2] = exc;
                  s_d.len = 6'h03;
                  s_d.st = mrs_pkg::ST_TX;
               end
            end
         end
         mrs_pkg::ST_READ:
         begin
            s_d.fb[5'(3 + 2 * s_q.idx)] = s_q.regs[widx][15:8];
            s_d.fb[5'(4 + 2 * s_q.idx)] = s_q.regs[widx][7:0];
            s_d.idx = s_q.idx + 4'h1;
            if (s_q.idx == s_q.qty - 4'h1)
            begin
               s_d.fb[2] = 8'(2 * s_q.qty);
               s_d.len = 6'(3 + 2 * s_q.qty);
               s_d.st = mrs_pkg::ST_TX;
            end
         end
         mrs_pkg::ST_WRITE:
         begin
            s_d.regs[widx] = wval;
            s_d.idx = s_q.idx + 4'h1;
            if (s_q.idx == s_q.qty - 4'h1) s_d.st = mrs_pkg::ST_CHECK;
         end
         mrs_pkg::ST_CHECK:
         begin
            s_d.st = bcast ? mrs_pkg::ST_RX : mrs_pkg::ST_TX;
            if (fc == mrs_pkg::FC_WR_ONE && s_q.regs[RW'(s_q.ra)] != qword && !bcast)
            begin
               s_d.fb[1] = fc | mrs_pkg::FC_EXC_FLAG;
               s_d.fb[2] = mrs_pkg::EXC_DEVICE;
               s_d.len = 6'h03;
            end
         end
         mrs_pkg::ST_TX:
         begin
            s_d.de = 1'b1;
            if (s_q.tcnt != 16'h0000) s_d.tcnt = s_q.tcnt - 16'h0001;
            else if (s_q.tbit != 4'h0)
            begin
               s_d.txd = s_q.tsh[0];
               s_d.tsh = {1'b1, s_q.tsh[10:1]};
               s_d.tbit = s_q.tbit - 4'h1;
               s_d.tcnt = bitdiv - 16'h0001;
            end
            else if (s_q.pos < s_q.len + 6'h02)
            begin
               // Eleven bits either way: parity plus one stop, or two stops
               s_d.tsh = {1'b1, par_en ? ((^tbyte) ^ (s_q.cfg.parity == mrs_pkg::PAR_ODD)) : 1'b1,
                          tbyte, 1'b0};
               s_d.tbit = 4'(mrs_pkg::BITS_PER_CHAR);
               s_d.pos = s_q.pos + 6'h01;
               if (s_q.pos < s_q.len) s_d.tcrc = crc_upd(s_q.tcrc, tbyte);
            end
            else
            begin
               s_d.de = 1'b0;
               s_d.txd = 1'b1;
               s_d.idle = '0;
               s_d.st = mrs_pkg::ST_RX;
            end
         end
         default: s_d.st = mrs_pkg::ST_RX;
      endcase
      if (s_q.st != mrs_pkg::ST_TX)
      begin
         s_d.pos = '0;
         s_d.tbit = '0;
         s_d.tcnt = '0;
         s_d.tcrc = mrs_pkg::CRC_INIT;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_q <= '0;
         s_q.rx_s1 <= 1'b1;
         s_q.rx_s2 <= 1'b1;
         s_q.idle <= '1;
         s_q.crc <= mrs_pkg::CRC_INIT;
         s_q.st <= mrs_pkg::ST_RX;
         s_q.txd <= 1'b1;
         s_q.cfg.station <= mrs_pkg::RST_STATION;
         s_q.cfg.baud <= mrs_pkg::RST_BAUD;
         s_q.cfg.parity <= mrs_pkg::RST_PARITY;
         s_q.cfg.timeout <= mrs_pkg::RST_TIMEOUT;
      end
      else
      begin
         s_q <= s_d;
      end
   end

endmodule // mrs_slave

// file: mrs_slave_properties.sv
// Port checks of the RTU serial slave, bound to each instance.
// Assumes baud code 5 and no parity, as the bench leaves them.
module mrs_slave_properties #(
   parameter int CLK_HZ = mrs_pkg::CLK_HZ
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic avs_waitrequest_o,
   input wire logic rs485_rx_i,
   input wire logic rs485_tx_o,
   input wire logic rs485_de_o,
   input wire logic invalid_length_fault_o,
   input wire logic bus_timeout_fault_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BD = CLK_HZ / 9600;
   // Idle is counted from the last low bit, so it never falls short of the true silence
   localparam int MIN_REST = 38 * BD;
   int idle_q;
   logic ctl_wr;
   assign ctl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == mrs_pkg::OFS_CTRL;
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         idle_q <= 0;
      else if (!rs485_rx_i)
         idle_q <= 0;
      else if (idle_q < MIN_REST)
         idle_q <= idle_q + 1;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   property p_rd_wait;
      $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait cycle wrong");
   property p_wr_wait;
      $rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
   endproperty
   a_wr_wait: assert property (p_wr_wait) else $error("write wait cycle wrong");
   property p_idle_tx;
      !rs485_de_o |-> rs485_tx_o;
   endproperty
   a_idle_tx: assert property (p_idle_tx) else $error("line not idle while released");
   property p_rest;
      $rose(rs485_de_o) |-> idle_q >= MIN_REST;
   endproperty
   a_rest: assert property (p_rest) else $error("answer before rest time");
   property p_start;
      $rose(rs485_de_o) |-> rs485_tx_o ##1 !rs485_tx_o;
   endproperty
   a_start: assert property (p_start) else $error("answer lacks start bit");
   property p_stop;
      $fell(rs485_de_o) |-> $past(rs485_tx_o) && $past(rs485_tx_o, BD + 1);
   endproperty
   a_stop: assert property (p_stop) else $error("answer lacks two stop bits");
   property p_len_stick;
      invalid_length_fault_o && !(ctl_wr && avs_writedata_i[2]) |=> invalid_length_fault_o;
   endproperty
   a_len_stick: assert property (p_len_stick) else $error("length fault lost");
   property p_tmo_stick;
      bus_timeout_fault_o && !(ctl_wr && avs_writedata_i[3]) |=> bus_timeout_fault_o;
   endproperty
   a_tmo_stick: assert property (p_tmo_stick) else $error("timeout fault lost");
   c_answer: cover property ($rose(rs485_de_o));
   c_len: cover property ($rose(invalid_length_fault_o));
   c_ctl: cover property (ctl_wr);
endmodule // mrs_slave_properties

bind mrs_slave mrs_slave_properties #(.CLK_HZ(CLK_HZ)) u_props (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_waitrequest_o(avs_waitrequest_o), .rs485_rx_i(rs485_rx_i), .rs485_tx_o(rs485_tx_o),
   .rs485_de_o(rs485_de_o), .invalid_length_fault_o(invalid_length_fault_o),
   .bus_timeout_fault_o(bus_timeout_fault_o));

// file: mrs_master_model.sv
// Serial master model: sends requests with CRC and collects answers.
// Assumes no parity and the slave's bit time of BD clock cycles.
module mrs_master_model #(
   parameter int BD = 10
) (
   input wire logic clk_i,
   input wire logic tx_i,
   input wire logic de_i,
   output logic rx_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got_q[$];
   logic [7:0] sh_q;
   initial rx_o = 1'b1;
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i])
      begin
         c = c ^ {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   task automatic send(input logic [7:0] b[$], input logic bad);
      logic [15:0] c;
      logic [10:0] f;
      c = crc16(b) ^ {15'h0000, bad};
      repeat (42 * BD) @(posedge clk_i);
      got_q.delete();
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
      foreach (b[i])
      begin
         f = {2'b11, b[i], 1'b0};
         for (int k = 0; k < 11; k++)
         begin
            rx_o <= f[k];
            repeat (BD) @(posedge clk_i);
         end
      end
   endtask
   // Checks start and enable at mid-bit, away from the edge where both change
   always @(negedge tx_i)
   begin
      repeat (BD / 2) @(posedge clk_i);
      if (!tx_i && de_i)
      begin
         for (int k = 0; k < 8; k++)
         begin
            repeat (BD) @(posedge clk_i);
            sh_q = {tx_i, sh_q[7:1]};
         end
         got_q.push_back(sh_q);
         repeat (BD) @(posedge clk_i);
      end
   end
endmodule // mrs_master_model

// file: mrs_slave_tb_top.sv
// Self-checking bench of the RTU slave with a serial master model.
// Assumes settings left at reset: station 1, 9600 baud, no parity.
module mrs_slave_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HZ = 38_400;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [3:0] be = 4'hF;
   logic [31:0] wd = 32'h00000000;
   logic [31:0] rdata;
   logic waitreq, rx, tx, de, lenf, tmof;
   logic [31:0] q;
   int fail_count = 0;
   int total_checks = 0;
   always #50 clk = ~clk;
   mrs_slave #(.CLK_HZ(HZ), .NREG(16)) uut (.clk_i(clk), .arst_n_i(arst_n),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
      .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .rs485_rx_i(rx), .rs485_tx_o(tx), .rs485_de_o(de),
      .invalid_length_fault_o(lenf), .bus_timeout_fault_o(tmof));
   mrs_master_model #(.BD(HZ / 9600)) plc (.clk_i(clk), .tx_i(tx), .de_i(de), .rx_o(rx));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (fail_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (waitreq !== 1'b0)
         @(posedge clk);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic xfer(input logic [7:0] req[$], input logic bad, input logic [7:0] rsp[$]);
      logic [15:0] c;
      int n;
      plc.send(req, bad);
      for (n = 0; de !== 1'b1 && n < 700; n++)
         @(posedge clk);
      while (de !== 1'b0)
         @(posedge clk);
      repeat (20) @(posedge clk);
      c = plc.crc16(rsp);
      if (rsp.size() > 0)
         rsp = {rsp, c[7:0], c[15:8]};
      check("answer size", plc.got_q.size(), rsp.size());
      foreach (rsp[i])
         check("answer byte", plc.got_q[i], rsp[i]);
   endtask
   task automatic t_regs();
      bus(1'b0, mrs_pkg::OFS_STATION, 32'h0);
      check("station", q, 32'h00000001);
      bus(1'b0, mrs_pkg::OFS_BAUD, 32'h0);
      check("baud", q, 32'h00000005);
      bus(1'b0, 8'h20, 32'h0);
      check("unmapped", q, 32'h00000000);
      bus(1'b1, mrs_pkg::OFS_HOLD + 8'h08, 32'h0000ABCD);
      bus(1'b1, mrs_pkg::OFS_HOLD + 8'h0C, 32'h00001357);
   endtask
   task automatic t_rw();
      xfer('{1, 3, 0, 2, 0, 2}, 1'b0, '{1, 3, 4, 8'hAB, 8'hCD, 8'h13, 8'h57});
      xfer('{1, 4, 0, 3, 0, 1}, 1'b0, '{1, 4, 2, 8'h13, 8'h57});
      xfer('{1, 6, 0, 5, 8'hBE, 8'hEF}, 1'b0, '{1, 6, 0, 5, 8'hBE, 8'hEF});
      xfer('{1, 8'h10, 0, 6, 0, 2, 4, 1, 2, 3, 4}, 1'b0,
         '{1, 8'h10, 0, 6, 0, 2, 4, 1, 2, 3, 4});
      bus(1'b0, mrs_pkg::OFS_HOLD + 8'h1C, 32'h0);
      check("fc10 reg", q, 32'h00000304);
   endtask
   task automatic t_exc();
      xfer('{1, 6, 8, 2, 0, 1}, 1'b0, '{1, 8'h86, 2});
      xfer('{1, 7, 0, 0, 0, 1}, 1'b0, '{1, 8'h87, 1});
      xfer('{1, 3, 0, 0, 0, 0}, 1'b0, '{1, 8'h83, 3});
      bus(1'b1, mrs_pkg::OFS_CTRL, 32'h00000002);
      xfer('{1, 6, 0, 5, 0, 0}, 1'b0, '{1, 8'h86, 6});
      bus(1'b1, mrs_pkg::OFS_CTRL, 32'h00000000);
      bus(1'b0, mrs_pkg::OFS_HOLD + 8'h14, 32'h0);
      check("no exec", q, 32'h0000BEEF);
   endtask
   task automatic t_silent();
      xfer('{2, 6, 0, 5, 0, 0}, 1'b0, '{});
      xfer('{1, 6, 0, 5, 0, 0}, 1'b1, '{});
      xfer('{0, 6, 0, 9, 8'h55, 8'hAA}, 1'b0, '{});
      xfer('{1, 3, 0, 0, 0, 8'h0C}, 1'b0, '{});
      check("length fault", lenf, 1'b1);
      bus(1'b0, mrs_pkg::OFS_HOLD + 8'h24, 32'h0);
      check("broadcast reg", q, 32'h000055AA);
      bus(1'b0, mrs_pkg::OFS_STATUS, 32'h0);
      check("status", q, 32'h0081000A);
      bus(1'b1, mrs_pkg::OFS_CTRL, 32'h00000005);
      bus(1'b0, mrs_pkg::OFS_STATUS, 32'h0);
      check("status cleared", q, 32'h00000000);
   endtask
   task automatic t_tmo();
      bus(1'b1, mrs_pkg::OFS_TIMEOUT, 32'h00000001);
      repeat (HZ - 8) @(posedge clk);
      check("early timeout", tmof, 1'b0);
      repeat (12) @(posedge clk);
      check("timeout fault", tmof, 1'b1);
      bus(1'b0, mrs_pkg::OFS_STATUS, 32'h0);
      check("status timeout", q, 32'h35000000);
      bus(1'b1, mrs_pkg::OFS_TIMEOUT, 32'h00000000);
      bus(1'b1, mrs_pkg::OFS_CTRL, 32'h00000008);
      check("timeout cleared", tmof, 1'b0);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_rw();
      t_exc();
      t_silent();
      t_tmo();
      stop_test();
   end
   // Twelve frames and one second of bus silence, with room to spare
   initial
   begin
      repeat (80000) @(posedge clk);
      fail_count++;
      stop_test();
   end
endmodule // mrs_slave_tb_top
